// *** rtl/ues_pkg.sv ***
// Notes on behaviour
// R1: With auto_tx_loaded set, a full-size packet loaded sets tx_packet_loaded by itself.
// R2: With two packets queued, tx_packet_loaded sets again after sending if the second is full-size.
// R3: IN control-2 bit 6 selects bulk/interrupt (0) or isochronous (1).
// R4: forced_toggle_switch 1 flips IN toggle on every sent packet; 0 only on ACK.
// R5: rx_max_packet counts 8-byte units; 128 means 1023 bytes.
// R6: Each OUT endpoint except 0 has its own rx_max_packet, reached via the index.
// R7: A written rx_max_packet above the OUT FIFO size is stored as the FIFO size.
// R8: rx_max_packet at most half the FIFO size allows two packets held at once.
// R9: Software must program rx_max_packet to match the endpoint descriptor.
// R10: Writing 1 to OUT control bit 7 zeroes the OUT toggle; bit reads 0.
// R11: halt_handshake_done sets on each STALL sent and holds until written 0.
// R12: halt_handshake_request makes STALL answers; ignored in isochronous mode.
// R13: Writing 1 to drop_next_packet discards the oldest packet in the OUT FIFO.
// R14: Isochronous only: packet_corrupt_flag shows with rx_packet_waiting for a damaged packet.
// R15: Isochronous only: an OUT packet with no room sets overrun until written 0.
// R16: rx_buffer_full reads 1 while the OUT FIFO has no room for a packet.
// R17: rx_packet_waiting sets on a received packet and raises an interrupt.
// R18: auto_rx_release clears rx_packet_waiting after a full-size packet is unloaded.
// R19: OUT control-2 bit 6 selects bulk/interrupt (0) or isochronous (1).
// R20: ctrl_ep_rx_bytes is 7 bits, valid only while endpoint 0 has a packet.
// R21: OUT byte count reads as 8 low and 3 high bits, valid while waiting.
// R22: Reserved low bits of both control-2 registers read zero.
package ues_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_INDEX       = 8'h0E;
    localparam logic [7:0] OFS_IN_CTRL2    = 8'h12;
    localparam logic [7:0] OFS_OUT_MAXP    = 8'h13;
    localparam logic [7:0] OFS_OUT_CSR1    = 8'h14;
    localparam logic [7:0] OFS_OUT_CTRL2   = 8'h15;
    localparam logic [7:0] OFS_RX_CNT_LOW  = 8'h16;
    localparam logic [7:0] OFS_RX_CNT_HIGH = 8'h17;
    localparam logic [7:0] OFS_IN_STATUS   = 8'h19;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_IN_AUTO      = 7;
    localparam int BIT_IN_ISO       = 6;
    localparam int BIT_IN_FORCED    = 3;
    localparam int BIT_TOGGLE_RESET = 7;
    localparam int BIT_HALT_DONE    = 6;
    localparam int BIT_HALT_REQ     = 5;
    localparam int BIT_DROP         = 4;
    localparam int BIT_CORRUPT      = 3;
    localparam int BIT_OVERRUN      = 2;
    localparam int BIT_FULL         = 1;
    localparam int BIT_WAITING      = 0;
    localparam int BIT_OUT_AUTO     = 7;
    localparam int BIT_OUT_ISO      = 6;
    localparam int BIT_TX_LOADED    = 0;
    localparam int BIT_TX_TOGGLE    = 1;
    // ****************************************
    // Reset values and sizes
    // ****************************************
    localparam logic [7:0]  RST_REG8      = 8'h00;
    localparam logic [7:0]  RST_IN_CTRL2  = 8'h20;
    localparam logic [7:0]  MAXP_ISO_CODE = 8'h80;
    localparam logic [10:0] MAXP_ISO_LEN  = 11'h3FF;
    localparam int          MAXP_UNIT     = 8;
endpackage : ues_pkg

// *** rtl/ues_endpoint.sv ***
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ues_endpoint #(
    parameter int NUM_EP        = 4,
    parameter int RX_FIFO_BYTES = 1024
) (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_tx_full_loaded,
    input  wire logic        i_tx_sent,
    input  wire logic        i_tx_ack,
    output logic             o_tx_packet_loaded,
    output logic             o_tx_toggle,
    output logic             o_tx_iso,
    input  wire logic        i_rx_done,
    input  wire logic [10:0] i_rx_len,
    input  wire logic        i_rx_crc_err,
    input  wire logic        i_rx_byte_read,
    input  wire logic        i_stall_sent,
    output logic             o_rx_room,
    output logic             o_rx_halt,
    output logic             o_rx_toggle,
    output logic             o_rx_iso,
    output logic             o_rx_irq,
    input  wire logic        i_ep0_rx_ready,
    input  wire logic [6:0]  i_ep0_rx_bytes
);
    // ****************************************
    // Parameter checks
    // ****************************************
    localparam logic [7:0] FIFO_UNITS = 8'(RX_FIFO_BYTES / ues_pkg::MAXP_UNIT);

    if (NUM_EP < 2 || NUM_EP > 16) begin : g_bad_num_ep
        $error("NUM_EP must lie between 2 and 16");
    end
    if (RX_FIFO_BYTES % ues_pkg::MAXP_UNIT != 0 || RX_FIFO_BYTES < 16 || RX_FIFO_BYTES > 1024) begin : g_bad_fifo
        $error("RX_FIFO_BYTES must be a multiple of 8 from 16 to 1024");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [10:0] maxp_bytes(input logic [7:0] v);
        if (v == ues_pkg::MAXP_ISO_CODE)
            return ues_pkg::MAXP_ISO_LEN; // R5
        return {v, 3'h0}; // R5
    endfunction

    function automatic logic [1:0] rx_capacity(input logic [7:0] v);
        return ({1'b0, v} <= {1'b0, FIFO_UNITS >> 1}) ? 2'h2 : 2'h1; // R8
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0]               idx;
        logic [NUM_EP-1:0][7:0]   rx_maxp;

        logic                     in_auto;
        logic                     in_iso;
        logic                     in_forced;
        logic                     tx_loaded;
        logic                     tx_second_max;
        logic                     tx_toggle;

        logic                     out_auto;
        logic                     out_iso;
        logic                     halt_req;
        logic                     halt_act;
        logic                     halt_done;
        logic                     overrun;
        logic                     rx_toggle;

        logic [1:0]               cnt;
        logic [10:0]              len0;
        logic [10:0]              len1;
        logic                     err0;
        logic                     err1;
        logic [10:0]              rd_cnt;
        logic                     waiting;
        logic                     room;
        logic                     irq;
        logic [7:0]               rdata;
    } ues_state_t;

    ues_state_t s;
    ues_state_t next_s;

    logic [7:0]  sel_maxp;
    logic [1:0]  cap;
    logic        sel_ok;
    logic        wr_csr1;
    logic        pop;
    logic        popped;
    logic        sw_set;
    logic [7:0]  rmux;

    always_comb begin
        sel_ok   = (s.idx != 4'h0) && ({28'h0, s.idx} < NUM_EP); // R6
        sel_maxp = sel_ok ? s.rx_maxp[s.idx] : 8'h00; // R6
        cap      = rx_capacity(sel_maxp);
        wr_csr1  = i_wr && (i_addr == ues_pkg::OFS_OUT_CSR1);
        sw_set   = i_wr && (i_addr == ues_pkg::OFS_IN_STATUS) && i_wdata[ues_pkg::BIT_TX_LOADED];
        pop      = 1'b0;
        popped   = 1'b0;
        rmux     = 8'h00;
        next_s   = s;

        // ****************************************
        // Register writes
        // ****************************************
        if (i_wr) begin
            unique case (i_addr)
                ues_pkg::OFS_INDEX: begin
                    next_s.idx = i_wdata[3:0];
                end
                ues_pkg::OFS_IN_CTRL2: begin
                    next_s.in_auto   = i_wdata[ues_pkg::BIT_IN_AUTO];
                    next_s.in_iso    = i_wdata[ues_pkg::BIT_IN_ISO]; // R3
                    next_s.in_forced = i_wdata[ues_pkg::BIT_IN_FORCED];
                end
                ues_pkg::OFS_OUT_MAXP: begin
                    if (sel_ok)
                        next_s.rx_maxp[s.idx] = (i_wdata > FIFO_UNITS) ? FIFO_UNITS : i_wdata; // R6 R7
                end
                ues_pkg::OFS_OUT_CSR1: begin
                    if (i_wdata[ues_pkg::BIT_TOGGLE_RESET])
                        next_s.rx_toggle = 1'b0; // R10
                    if (!i_wdata[ues_pkg::BIT_HALT_DONE])
                        next_s.halt_done = 1'b0;
                    if (!i_wdata[ues_pkg::BIT_OVERRUN])
                        next_s.overrun = 1'b0;
                    next_s.halt_req = i_wdata[ues_pkg::BIT_HALT_REQ];
                    if (i_wdata[ues_pkg::BIT_DROP])
                        pop = 1'b1; // R13
                    if (!i_wdata[ues_pkg::BIT_WAITING] && s.waiting)
                        pop = 1'b1; // R17
                end
                ues_pkg::OFS_OUT_CTRL2: begin
                    next_s.out_auto = i_wdata[ues_pkg::BIT_OUT_AUTO];
                    next_s.out_iso  = i_wdata[ues_pkg::BIT_OUT_ISO]; // R19
                end
                ues_pkg::OFS_IN_STATUS: begin
                    if (i_wdata[ues_pkg::BIT_TX_LOADED])
                        next_s.tx_loaded = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // ****************************************
        // IN side
        // ****************************************
        if (i_tx_sent) begin
            next_s.tx_loaded     = (s.in_auto && s.tx_second_max) || sw_set; // R2
            next_s.tx_second_max = 1'b0;
            if (s.in_forced || i_tx_ack)
                next_s.tx_toggle = !s.tx_toggle; // R4
        end
        if (i_tx_full_loaded && s.in_auto) begin
            if (s.tx_loaded && !i_tx_sent)
                next_s.tx_second_max = 1'b1; // R2
            else
                next_s.tx_loaded = 1'b1; // R1
        end

        // ****************************************
        // OUT side: unload, then receive
        // ****************************************
        if (i_rx_byte_read && s.waiting) begin
            next_s.rd_cnt = s.rd_cnt + 11'h001;
            if (s.out_auto && s.len0 == maxp_bytes(sel_maxp) && s.rd_cnt + 11'h001 == s.len0)
                pop = 1'b1; // R18
        end
        if (i_stall_sent)
            next_s.halt_done = 1'b1; // R11
        if (pop && s.cnt != 2'h0) begin
            popped        = 1'b1;
            next_s.cnt    = s.cnt - 2'h1;
            next_s.len0   = s.len1;
            next_s.err0   = s.err1;
            next_s.rd_cnt = 11'h000;
        end
        if (i_rx_done) begin
            if (s.room) begin
                if (next_s.cnt == 2'h0) begin
                    next_s.len0 = i_rx_len;
                    next_s.err0 = i_rx_crc_err;
                end else begin
                    next_s.len1 = i_rx_len;
                    next_s.err1 = i_rx_crc_err;
                end
                next_s.cnt = next_s.cnt + 2'h1;
                if (!s.out_iso)
                    next_s.rx_toggle = !next_s.rx_toggle;
            end else if (s.out_iso) begin
                next_s.overrun = 1'b1; // R15
            end
        end
        next_s.waiting  = (next_s.cnt != 2'h0); // R17
        next_s.irq      = next_s.waiting && (!s.waiting || popped); // R17
        next_s.room     = (next_s.cnt < rx_capacity(next_s.idx == s.idx ? sel_maxp : 8'hFF)); // R16
        next_s.halt_act = next_s.halt_req && !next_s.out_iso; // R12

        // ****************************************
        // Read data, valid in the cycle after the strobe
        // ****************************************
        unique case (i_addr)
            ues_pkg::OFS_INDEX:
                rmux = {4'h0, s.idx};
            ues_pkg::OFS_IN_CTRL2:
                rmux = {s.in_auto, s.in_iso, ues_pkg::RST_IN_CTRL2[5], 1'b0, s.in_forced, 3'b000}; // R22
            ues_pkg::OFS_OUT_MAXP:
                rmux = sel_maxp;
            ues_pkg::OFS_OUT_CSR1:
                rmux = {1'b0, s.halt_done, s.halt_req, 1'b0,
                        s.waiting && s.out_iso && s.err0, s.overrun, // R14
                        s.cnt == cap, s.waiting}; // R16
            ues_pkg::OFS_OUT_CTRL2:
                rmux = {s.out_auto, s.out_iso, 6'h00}; // R22
            ues_pkg::OFS_RX_CNT_LOW:
                if (s.idx == 4'h0)
                    rmux = i_ep0_rx_ready ? {1'b0, i_ep0_rx_bytes} : 8'h00; // R20
                else
                    rmux = s.waiting ? s.len0[7:0] : 8'h00; // R21
            ues_pkg::OFS_RX_CNT_HIGH:
                rmux = s.waiting ? {5'h00, s.len0[10:8]} : 8'h00; // R21
            ues_pkg::OFS_IN_STATUS:
                rmux = {6'h00, s.tx_toggle, s.tx_loaded};
            default:
                rmux = 8'h00;
        endcase
        next_s.rdata = i_rd ? rmux : 8'h00;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s      <= '0;
            s.room <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rdata            = s.rdata;

    assign o_tx_packet_loaded = s.tx_loaded;
    assign o_tx_toggle        = s.tx_toggle;
    assign o_tx_iso           = s.in_iso;

    assign o_rx_room          = s.room;
    assign o_rx_halt          = s.halt_act;
    assign o_rx_toggle        = s.rx_toggle;
    assign o_rx_iso           = s.out_iso;
    assign o_rx_irq           = s.irq;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence seq_auto_full;
        s.in_auto && !s.tx_loaded && i_tx_full_loaded && !i_tx_sent;
    endsequence

    sequence seq_sent_second;
        s.in_auto && s.tx_second_max && i_tx_sent;
    endsequence

    a_auto_tx_set: assert property (seq_auto_full |=> o_tx_packet_loaded) // R1
        else $error("auto set of tx flag missing");

    a_second_packet_set: assert property (seq_sent_second |=> o_tx_packet_loaded) // R2
        else $error("second full packet did not re-set tx flag");

    a_tx_flag_clear: assert property (i_tx_sent && !s.tx_second_max && !i_tx_full_loaded && !sw_set // R2
                                      |=> !o_tx_packet_loaded)
        else $error("tx flag not cleared after sending");

    a_in_iso_bit: assert property (i_wr && i_addr == ues_pkg::OFS_IN_CTRL2 |=> o_tx_iso == $past(i_wdata[6])) // R3
        else $error("IN iso bit not stored");

    a_forced_toggle: assert property (i_tx_sent && s.in_forced |=> o_tx_toggle != $past(o_tx_toggle)) // R4
        else $error("forced toggle did not flip");

    a_toggle_hold: assert property (i_tx_sent && !s.in_forced && !i_tx_ack |=> o_tx_toggle == $past(o_tx_toggle)) // R4
        else $error("toggle flipped without ack");

    // ****************************************
    // OUT side assertions
    // ****************************************
    sequence seq_last_byte;
        s.out_auto && s.cnt == 2'h1 && i_rx_byte_read && !i_rx_done &&
        s.len0 == maxp_bytes(sel_maxp) && s.rd_cnt + 11'h001 == s.len0;
    endsequence

    a_maxp_clamp: assert property (i_wr && i_addr == ues_pkg::OFS_OUT_MAXP && sel_ok && i_wdata > FIFO_UNITS // R7
                                   |=> s.rx_maxp[$past(s.idx)] == FIFO_UNITS)
        else $error("max packet not clamped");

    a_maxp_select: assert property (i_wr && i_addr == ues_pkg::OFS_OUT_MAXP && !sel_ok // R6
                                    |=> $stable(s.rx_maxp))
        else $error("max packet written without a valid index");

    a_toggle_reset: assert property (wr_csr1 && i_wdata[7] && !i_rx_done |=> !o_rx_toggle) // R10
        else $error("OUT toggle not reset");

    a_halt_sticky: assert property (i_stall_sent |=> s.halt_done) // R11
        else $error("stall sent flag not set");

    a_halt_hold: assert property (s.halt_done && !wr_csr1 |=> s.halt_done) // R11
        else $error("stall sent flag dropped by itself");

    a_halt_iso: assert property (s.out_iso |-> !o_rx_halt) // R12
        else $error("stall given in iso mode");

    a_halt_active: assert property (s.halt_req && !s.out_iso |-> o_rx_halt) // R12
        else $error("stall request not answered");

    a_drop_packet: assert property (wr_csr1 && i_wdata[4] && s.cnt == 2'h2 && !i_rx_done |=> s.cnt == 2'h1) // R13
        else $error("flush did not drop one packet");

    a_overrun_set: assert property (i_rx_done && !s.room && s.out_iso |=> s.overrun) // R15
        else $error("iso overrun not flagged");

    a_overrun_hold: assert property (s.overrun && !wr_csr1 |=> s.overrun) // R15
        else $error("overrun flag dropped by itself");

    a_room_full: assert property (s.cnt == 2'h2 |-> !o_rx_room) // R16
        else $error("room shown with two packets held");

    a_rx_waiting: assert property (i_rx_done && s.room |=> s.waiting) // R17
        else $error("packet received but not flagged");

    a_rx_irq: assert property (i_rx_done && s.room && s.cnt == 2'h0 |=> o_rx_irq ##1 !o_rx_irq) // R17
        else $error("packet interrupt not one pulse");

    a_auto_release: assert property (seq_last_byte |=> !s.waiting) // R18
        else $error("auto release did not clear the flag");

    a_out_iso_bit: assert property (i_wr && i_addr == ues_pkg::OFS_OUT_CTRL2 // R19
                                    |=> o_rx_iso == $past(i_wdata[6]))
        else $error("OUT iso bit not stored");

    // ****************************************
    // Register read assertions
    // ****************************************
    a_ep0_count: assert property (i_rd && i_addr == ues_pkg::OFS_RX_CNT_LOW && s.idx == 4'h0 // R20
                                  |=> !o_rdata[7])
        else $error("control endpoint count wider than 7 bits");

    a_count_window: assert property (i_rd && i_addr == ues_pkg::OFS_RX_CNT_HIGH && !s.waiting // R21
                                     |=> o_rdata == 8'h00)
        else $error("byte count shown with no packet waiting");

    a_corrupt_window: assert property (i_rd && i_addr == ues_pkg::OFS_OUT_CSR1 && !s.out_iso // R14
                                       |=> !o_rdata[3])
        else $error("data error shown outside iso mode");

    a_ctrl2_low: assert property (i_rd && (i_addr == ues_pkg::OFS_IN_CTRL2 || i_addr == ues_pkg::OFS_OUT_CTRL2) // R22
                                  |=> o_rdata[2:0] == 3'h0)
        else $error("reserved control bits not zero");

    a_read_window: assert property (!i_rd |=> o_rdata == 8'h00) // read data reads zero outside the cycle after the strobe
        else $error("read data outside its cycle");
endmodule // ues_endpoint
`default_nettype wire

// *** bench/ues_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ues_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_out_go,
    input  wire logic [10:0] i_out_len,
    input  wire logic        i_out_bad,
    input  wire logic        i_in_go,
    input  wire logic        i_in_ack,
    input  wire logic        i_rx_halt,
    output logic             o_rx_done,
    output logic      [10:0] o_rx_len,
    output logic             o_rx_crc_err,
    output logic             o_tx_sent,
    output logic             o_tx_ack,
    output logic             o_stall_sent
);
    // ****************************************
    // Host tokens, data and handshakes
    // ****************************************
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_done    <= 1'b0;
            o_rx_len     <= 11'h000;
            o_rx_crc_err <= 1'b0;
            o_tx_sent    <= 1'b0;
            o_tx_ack     <= 1'b0;
            o_stall_sent <= 1'b0;
        end else begin
            // Halted endpoint answers STALL instead of taking data
            o_rx_done    <= i_out_go && !i_rx_halt;
            o_stall_sent <= i_out_go && i_rx_halt;
            // Outside a packet the qualifiers keep changing
            o_rx_len     <= i_out_go ? i_out_len : ~o_rx_len;
            o_rx_crc_err <= i_out_go ? i_out_bad : ~o_rx_crc_err;
            o_tx_sent    <= i_in_go;
            o_tx_ack     <= i_in_go && i_in_ack;
        end
    end
endmodule // ues_host_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb;
    logic        i_clock, i_resetn, i_wr, i_rd, fl, rb, ep0_rdy, out_go, out_bad, in_go, in_ack;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    logic [6:0]  ep0_bytes;
    logic [10:0] out_len, rx_len;
    logic        tx_ld, tx_tog, tx_iso, room, halt, rx_tog, rx_iso, irq;
    logic        rx_done, crc, tx_sent, tx_ack, stall;
    int          bad_count, comparisons, irq_count;
    ues_endpoint #(.NUM_EP(4), .RX_FIFO_BYTES(1024)) ues_endpoint_i (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_full_loaded(fl),
        .i_tx_sent(tx_sent), .i_tx_ack(tx_ack), .o_tx_packet_loaded(tx_ld),
        .o_tx_toggle(tx_tog), .o_tx_iso(tx_iso), .i_rx_done(rx_done), .i_rx_len(rx_len),
        .i_rx_crc_err(crc), .i_rx_byte_read(rb), .i_stall_sent(stall), .o_rx_room(room),
        .o_rx_halt(halt), .o_rx_toggle(rx_tog), .o_rx_iso(rx_iso), .o_rx_irq(irq),
        .i_ep0_rx_ready(ep0_rdy), .i_ep0_rx_bytes(ep0_bytes));
    ues_host_model ues_host_model_i (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_out_go(out_go), .i_out_len(out_len),
        .i_out_bad(out_bad), .i_in_go(in_go), .i_in_ack(in_ack), .i_rx_halt(halt),
        .o_rx_done(rx_done), .o_rx_len(rx_len), .o_rx_crc_err(crc), .o_tx_sent(tx_sent),
        .o_tx_ack(tx_ack), .o_stall_sent(stall));
    // ****************************************
    // Clock, counters and bus tasks
    // ****************************************
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) if (irq === 1'b1) irq_count++;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock); i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clock); i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock); i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask
    task automatic host_out(input logic [10:0] len, input logic bad);
        @(posedge i_clock); out_go <= 1'b1; out_len <= len; out_bad <= bad;
        @(posedge i_clock); out_go <= 1'b0; out_len <= ~len; out_bad <= ~bad;
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    task automatic host_in(input logic ack);
        @(posedge i_clock); in_go <= 1'b1; in_ack <= ack;
        @(posedge i_clock); in_go <= 1'b0; in_ack <= ~ack;
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    task automatic full_loaded();
        @(posedge i_clock); fl <= 1'b1;
        @(posedge i_clock); fl <= 1'b0;
        @(posedge i_clock);
        #1;
    endtask
    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        `CHK(room, 1'b1)
        rd(8'h14, 8'h00);
        rd(8'h15, 8'h00);
        rd(8'h12, 8'h20);
        rd(8'h30, 8'h00);
    endtask
    task automatic t_maxp();
        wr(8'h0E, 8'h01); wr(8'h13, 8'hFF);
        rd(8'h13, 8'h80);
        wr(8'h0E, 8'h02); wr(8'h13, 8'h10);
        rd(8'h13, 8'h10);
        wr(8'h0E, 8'h01);
        rd(8'h13, 8'h80);
        wr(8'h0E, 8'h00); wr(8'h13, 8'h05);
        rd(8'h13, 8'h00);
    endtask
    task automatic t_double();
        wr(8'h0E, 8'h01); wr(8'h13, 8'h40);
        irq_count = 0;
        host_out(11'h1A5, 1'b0);
        `CHK(irq_count, 1)
        `CHK(rx_tog, 1'b1)
        rd(8'h14, 8'h01);
        rd(8'h16, 8'hA5);
        rd(8'h17, 8'h01);
        wr(8'h14, 8'h81);
        #1 `CHK(rx_tog, 1'b0)
        rd(8'h14, 8'h01);
        host_out(11'h020, 1'b0);
        rd(8'h14, 8'h03);
        `CHK(room, 1'b0)
        host_out(11'h0BB, 1'b0);
        rd(8'h16, 8'hA5);
        wr(8'h14, 8'h11);
        rd(8'h16, 8'h20);
        rd(8'h14, 8'h01);
        wr(8'h14, 8'h11);
        rd(8'h14, 8'h00);
    endtask
    task automatic t_stall();
        wr(8'h14, 8'h20);
        #1 `CHK(halt, 1'b1)
        host_out(11'h010, 1'b0);
        rd(8'h14, 8'h60);
        wr(8'h14, 8'h00);
        rd(8'h14, 8'h00);
        `CHK(halt, 1'b0)
    endtask
    task automatic t_iso();
        wr(8'h15, 8'hFF);
        rd(8'h15, 8'hC0);
        `CHK(rx_iso, 1'b1)
        wr(8'h14, 8'h20);
        #1 `CHK(halt, 1'b0)
        wr(8'h14, 8'h00); wr(8'h13, 8'h80);
        host_out(11'h040, 1'b1);
        rd(8'h14, 8'h0B);
        host_out(11'h040, 1'b0);
        rd(8'h14, 8'h0F);
        wr(8'h14, 8'h01);
        rd(8'h14, 8'h0B);
        wr(8'h14, 8'h00);
        rd(8'h14, 8'h00);
        wr(8'h15, 8'h00);
        #1 `CHK(rx_iso, 1'b0)
    endtask
    task automatic t_auto();
        wr(8'h15, 8'h80);
        host_out(11'h3FF, 1'b0);
        rd(8'h17, 8'h03);
        rd(8'h16, 8'hFF);
        @(posedge i_clock); rb <= 1'b1;
        repeat (1022) @(posedge i_clock);
        rb <= 1'b0;
        rd(8'h14, 8'h03);
        @(posedge i_clock); rb <= 1'b1;
        @(posedge i_clock); rb <= 1'b0;
        rd(8'h14, 8'h00);
        @(posedge i_clock); ep0_bytes <= 7'h55; ep0_rdy <= 1'b1;
        wr(8'h0E, 8'h00);
        rd(8'h16, 8'h55);
    endtask
    task automatic t_in();
        wr(8'h12, 8'hFF);
        rd(8'h12, 8'hE8);
        `CHK(tx_iso, 1'b1)
        full_loaded();
        `CHK(tx_ld, 1'b1)
        full_loaded();
        host_in(1'b0);
        `CHK(tx_ld, 1'b1)
        `CHK(tx_tog, 1'b1)
        host_in(1'b0);
        `CHK(tx_ld, 1'b0)
        wr(8'h12, 8'h80);
        host_in(1'b0);
        `CHK(tx_tog, 1'b0)
        `CHK(tx_iso, 1'b0)
        host_in(1'b1);
        `CHK(tx_tog, 1'b1)
        rd(8'h19, 8'h02);
    endtask
    initial begin
        {i_resetn, i_wr, i_rd, fl, rb, ep0_rdy, out_go, out_bad, in_go, in_ack} = '0;
        {i_addr, i_wdata, ep0_bytes, out_len} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_reset(); t_maxp(); t_double(); t_stall(); t_iso(); t_auto(); t_in();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        complete_run();
    end
endmodule // tb
`default_nettype wire
